// ==== cq_interrupt_signaling.sv ====
// Interrupt generation for completion queues: wire, single and multiple message, and extended message modes.
// Functional notes
// [RULE_01] Wire mode when message enable is zero and extended messages are disabled.
// [RULE_02] Single-message mode: message enable one, vector count field zero, extended off.
// [RULE_03] Multi-message mode: message enable one, vector count field one, extended off.
// [RULE_04] Hidden status vector, one bit per vector, decides wire level or message.
// [RULE_05] Status bit set only with pending entries, interrupts enabled, vector unmasked; the code applies no mask to status in extended mode.
// [RULE_06] Without messages, wire is driven low while status bit zero is one.
// [RULE_07] Message on an unmasked status rise, or unmasking a vector whose status is set.
// [RULE_08] Host clears a vector by acknowledging all entries of its queues.
// [RULE_09] Partial clear keeps wire active, or sends a fresh message in message modes.
// [RULE_10] All status bits clear: wire released, no message sent.
// [RULE_11] Ones written to mask-set register set those vectors' mask bits.
// [RULE_12] Ones written to mask-clear register clear those vectors' mask bits.
// [RULE_13] Head doorbell writes acknowledge entries; vector drops once all are acknowledged.
// [RULE_14] One vector in wire and single modes, at most 32 in multi mode.
// [RULE_15] Capable count advertises requested vectors as next power-of-two exponent.
// [RULE_16] Extended mode: message enable zero, count field zero, extended enabled.
// [RULE_17] Extended mode supports many vectors, each with its own message data.
// [RULE_18] Extended message sent only with function mask and vector mask both clear; the code tests both masks only when the request is raised.
// [RULE_19] Masked extended message sets pending bit, sent once both masks clear.
// [RULE_20] Host should mask, process and acknowledge, then unmask in its handler.
// [RULE_21] Administrative queue interrupts are never delayed by coalescing.
// [RULE_22] Queue has unacknowledged entries while tail differs from last doorbell head.
// [RULE_23] Reset clears status, mask and pending bits and releases the wire.
`timescale 1ns/10ps
`default_nettype none
module cq_interrupt_signaling (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Queue activity
    input wire cq_irq_pkg::cq_config_s cq_config,
    input wire cq_irq_pkg::cq_event_s cq_tail_update,
    input wire cq_irq_pkg::cq_event_s cq_head_doorbell,
    // Mask registers
    input wire cq_irq_pkg::mask_write_s mask_set_register,
    input wire cq_irq_pkg::mask_write_s mask_clear_register,
    // Configuration
    input wire cq_irq_pkg::irq_cfg_s irq_cfg,
    input wire logic [cq_irq_pkg::DATA_W-1:0] msi_base_data,
    input wire logic [cq_irq_pkg::NUM_VEC-1:0] ext_vector_mask,
    input wire cq_irq_pkg::table_write_s ext_table_write,
    // Message output
    output cq_irq_pkg::msg_s msg,
    input wire logic msg_ready,
    // Wire and status
    output logic intx_n,
    output logic [cq_irq_pkg::NUM_VEC-1:0] vector_mask_bits,
    output logic [cq_irq_pkg::NUM_VEC-1:0] pending_bits,
    output logic [cq_irq_pkg::CAP_W-1:0] capable_vector_count,
    output cq_irq_pkg::mode_e mode
);
    import cq_irq_pkg::*;

    typedef struct packed {
        logic [NUM_CQ-1:0] cq_valid;
        logic [NUM_CQ-1:0] cq_ien;
        logic [NUM_CQ-1:0][VEC_W-1:0] cq_vec;
        logic [NUM_CQ-1:0][PTR_W-1:0] cq_tail;
        logic [NUM_CQ-1:0][PTR_W-1:0] cq_head;
        logic [NUM_VEC-1:0] mask;
        logic [NUM_VEC-1:0] status;
        logic [NUM_VEC-1:0] request;
        logic [NUM_VEC-1:0] pending;
        logic [NUM_VEC-1:0][DATA_W-1:0] ext_data;
        logic intx_n;
        msg_s msg;
        logic [CAP_W-1:0] cap;
        mode_e mode;
    } state_s;

    state_s s_reg;
    state_s s_next;
    logic pick_found;
    logic [VEC_W-1:0] pick_idx;
    logic [NUM_VEC-1:0] cond;
    logic [NUM_VEC-1:0] is_now;
    logic [NUM_VEC-1:0] rise;
    logic [NUM_VEC-1:0] fall;
    logic [NUM_VEC-1:0] release_bits;
    logic ext_blocked;
    mode_e mode_now;

    function automatic mode_e decode_mode(input irq_cfg_s c);
        mode_e m;
        m = MODE_OFF;
        if (!c.message_interrupt_enable && !c.ext_enable)
        begin
            m = MODE_WIRE; // [RULE_01]
        end
        else if (c.message_interrupt_enable && !c.ext_enable && c.enabled_vector_count == VCNT_SINGLE)
        begin
            m = MODE_SINGLE; // [RULE_02]
        end
        else if (c.message_interrupt_enable && !c.ext_enable && c.enabled_vector_count >= VCNT_MULTI)
        begin
            m = MODE_MULTI; // [RULE_03]
        end
        else if (!c.message_interrupt_enable && c.ext_enable && c.enabled_vector_count == VCNT_SINGLE)
        begin
            m = MODE_EXT; // [RULE_16]
        end
        return m;
    endfunction

    // Folds a queue's vector number into the vectors the current mode really owns.
    function automatic logic [VEC_W-1:0] map_vec(input logic [VEC_W-1:0] v, input mode_e m,
                                                 input logic [CAP_W-1:0] vcount);
        logic [CAP_W-1:0] e;
        logic [VEC_W:0] span;
        logic [VEC_W-1:0] r;
        e = (vcount > VCNT_MAX) ? VCNT_MAX : vcount;
        span = (VEC_W + 1)'(1) << e;
        r = VEC_IDX_ZERO; // [RULE_14]
        if (m == MODE_MULTI)
        begin
            r = v & VEC_W'(span - (VEC_W + 1)'(1)); // [RULE_14]
        end
        else if (m == MODE_EXT)
        begin
            r = v;
        end
        return r;
    endfunction

    vec_pick pick_u (
        .req(s_reg.request),
        .found(pick_found),
        .idx(pick_idx)
    );

    always_comb
    begin
        s_next = s_reg;
        mode_now = decode_mode(irq_cfg);
        s_next.mode = mode_now;
        s_next.cap = pow2_exponent(REQ_VECTORS); // [RULE_15]

        // Queue table updates; a create in the same cycle overrides pointer events.
        if (cq_tail_update.valid)
        begin
            s_next.cq_tail[cq_tail_update.qid] = cq_tail_update.ptr;
        end
        if (cq_head_doorbell.valid)
        begin
            s_next.cq_head[cq_head_doorbell.qid] = cq_head_doorbell.ptr; // [RULE_13]
        end
        if (cq_config.valid)
        begin
            s_next.cq_valid[cq_config.qid] = cq_config.create;
            s_next.cq_ien[cq_config.qid] = cq_config.ien;
            s_next.cq_vec[cq_config.qid] = cq_config.vector;
            s_next.cq_tail[cq_config.qid] = PTR_RESET;
            s_next.cq_head[cq_config.qid] = PTR_RESET;
        end

        // Mask writes; a vector both set and cleared in one cycle ends masked.
        if (mask_clear_register.valid)
        begin
            s_next.mask = s_next.mask & ~mask_clear_register.data; // [RULE_12]
        end
        if (mask_set_register.valid)
        begin
            s_next.mask = s_next.mask | mask_set_register.data; // [RULE_11]
        end

        if (ext_table_write.valid)
        begin
            s_next.ext_data[ext_table_write.index] = ext_table_write.data; // [RULE_17]
        end

        // Every queue with interrupts enabled, the administrative one included, raises its vector at once, with no aggregation delay.
        cond = VEC_ZERO; // [RULE_21]
        for (int q = 0; q < NUM_CQ; q++)
        begin
            if (s_next.cq_valid[q] && s_next.cq_ien[q] && s_next.cq_tail[q] != s_next.cq_head[q]) // [RULE_22]
            begin
                cond[map_vec(s_next.cq_vec[q], mode_now, irq_cfg.enabled_vector_count)] = 1'b1; // [RULE_05]
            end
        end

        // The host mask only gates the hidden status outside extended mode.
        if (mode_now == MODE_EXT)
        begin
            is_now = cond;
        end
        else if (mode_now == MODE_OFF)
        begin
            is_now = VEC_ZERO;
        end
        else
        begin
            is_now = cond & ~s_next.mask; // [RULE_04] [RULE_05]
        end
        s_next.status = is_now; // [RULE_04]
        rise = is_now & ~s_reg.status;
        fall = s_reg.status & ~is_now;
        ext_blocked = irq_cfg.ext_function_mask;
        release_bits = VEC_ZERO;

        // Wire is low while status bit zero stands; drops back when all clear.
        s_next.intx_n = !(mode_now == MODE_WIRE && is_now[0]); // [RULE_06] [RULE_09] [RULE_10]

        // Retire the message handed over, then load the next; new requests below win over this clear.
        if (s_reg.msg.valid && msg_ready)
        begin
            s_next.msg.valid = 1'b0;
        end
        if (!s_reg.msg.valid && pick_found)
        begin
            s_next.request[pick_idx] = 1'b0;
            s_next.msg.valid = 1'b1;
            s_next.msg.vector = {{(EXT_VEC_W - VEC_W){1'b0}}, pick_idx};
            if (s_reg.mode == MODE_EXT)
            begin
                s_next.msg.data = s_reg.ext_data[pick_idx]; // [RULE_17]
            end
            else
            begin
                s_next.msg.data = {msi_base_data[DATA_W-1:VEC_W], msi_base_data[VEC_W-1:0] | pick_idx};
            end
        end

        unique case (mode_now)
            MODE_SINGLE, MODE_MULTI:
            begin
                // An unmask of a set vector shows here as a rise, since status includes the mask.
                s_next.request = s_next.request | rise; // [RULE_07]
                if (|fall && |is_now)
                begin
                    s_next.request = s_next.request | is_now; // [RULE_09]
                end
            end
            MODE_EXT:
            begin
                // Masks are sampled when the edge is seen; a mask set later does not hold back a request already raised.
                for (int v = 0; v < NUM_VEC; v++)
                begin
                    if (rise[v])
                    begin
                        if (ext_blocked || ext_vector_mask[v])
                        begin
                            s_next.pending[v] = 1'b1; // [RULE_19]
                        end
                        else
                        begin
                            s_next.request[v] = 1'b1; // [RULE_18]
                        end
                    end
                end
                release_bits = s_reg.pending & ~ext_vector_mask & {NUM_VEC{~ext_blocked}}; // [RULE_18]
                s_next.pending = s_next.pending & ~release_bits; // [RULE_19]
                s_next.request = s_next.request | release_bits; // [RULE_19]
            end
            MODE_WIRE, MODE_OFF:
            begin
                s_next.request = VEC_ZERO;
            end
        endcase

        // Old requests make no sense under a new signalling scheme.
        if (mode_now != s_reg.mode)
        begin
            s_next.request = VEC_ZERO;
            s_next.pending = VEC_ZERO;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_reg <= '0; // [RULE_23]
            s_reg.intx_n <= 1'b1; // [RULE_23]
            s_reg.mode <= MODE_OFF;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign msg = s_reg.msg;
    assign intx_n = s_reg.intx_n;
    assign vector_mask_bits = s_reg.mask;
    assign pending_bits = s_reg.pending;
    assign capable_vector_count = s_reg.cap;
    assign mode = s_reg.mode;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    wire_level_a: // [RULE_06]
    assert property ((s_reg.mode == MODE_WIRE && s_reg.status[0]) |-> !intx_n)
    else $error("wire not active while status bit zero set");

    wire_release_a: // [RULE_10]
    assert property ((s_reg.mode != MODE_WIRE || s_reg.status == VEC_ZERO) |-> intx_n)
    else $error("wire active without cause");

    single_mode_a: // [RULE_02]
    assert property ((irq_cfg.message_interrupt_enable && !irq_cfg.ext_enable
                      && irq_cfg.enabled_vector_count == VCNT_SINGLE) |=> mode == MODE_SINGLE)
    else $error("single message mode not selected");

    multi_mode_a: // [RULE_03]
    assert property ((irq_cfg.message_interrupt_enable && !irq_cfg.ext_enable
                      && irq_cfg.enabled_vector_count == VCNT_MULTI) |=> mode == MODE_MULTI)
    else $error("multi message mode not selected");

    ext_mode_a: // [RULE_16]
    assert property ((!irq_cfg.message_interrupt_enable && irq_cfg.ext_enable
                      && irq_cfg.enabled_vector_count == VCNT_SINGLE) |=> mode == MODE_EXT)
    else $error("extended mode not selected");

    mask_set_a: // [RULE_11]
    assert property (mask_set_register.valid |=>
                     ((vector_mask_bits & $past(mask_set_register.data)) == $past(mask_set_register.data)))
    else $error("mask set write not applied");

    mask_clear_a: // [RULE_12]
    assert property ((mask_clear_register.valid && !mask_set_register.valid) |=>
                     ((vector_mask_bits & $past(mask_clear_register.data)) == VEC_ZERO))
    else $error("mask clear write not applied");

    masked_status_a: // [RULE_05]
    assert property ((mode == MODE_SINGLE || mode == MODE_MULTI || mode == MODE_WIRE)
                     |-> ((s_reg.status & vector_mask_bits) == VEC_ZERO))
    else $error("status set on a masked vector");

    rise_message_a: // [RULE_07]
    assert property ((mode_now == s_reg.mode && (mode_now == MODE_SINGLE || mode_now == MODE_MULTI)
                      && |rise) |=> (s_reg.request != VEC_ZERO || msg.valid) [*2])
    else $error("status rise produced no message");

    message_issue_a: // [RULE_07]
    assert property ((s_reg.request != VEC_ZERO && !msg.valid) |=> msg.valid)
    else $error("queued message not issued");

    msg_hold_a: // [RULE_07]
    assert property ((msg.valid && !msg_ready) |=> (msg.valid && $stable(msg)))
    else $error("message changed before it was taken");

    ext_pending_a: // [RULE_19]
    assert property ((mode_now == MODE_EXT && mode_now == s_reg.mode && |rise && irq_cfg.ext_function_mask)
                     |=> pending_bits != VEC_ZERO)
    else $error("masked extended message not held pending");

    ext_release_a: // [RULE_18]
    assert property ((mode == MODE_EXT && mode_now == MODE_EXT && |release_bits)
                     |=> (pending_bits & $past(release_bits)) == VEC_ZERO)
    else $error("pending bit not released after unmask");

    single_vector_a: // [RULE_14]
    assert property ((mode == MODE_WIRE || mode == MODE_SINGLE) |-> (s_reg.status & ~VEC_ONE) == VEC_ZERO)
    else $error("extra vector used in single vector mode");

    capable_count_a: // [RULE_15]
    // The count loads at the first edge after reset, so only check once a full cycle out of reset has passed.
    assert property ($past(rst_n) |-> capable_vector_count == pow2_exponent(REQ_VECTORS))
    else $error("capable count wrong");
endmodule
`default_nettype wire

// ==== cq_irq_pkg.sv ====
// Shared constants and types for the completion-queue interrupt signalling block.
package cq_irq_pkg;

    localparam int NUM_VEC = 32;
    localparam int VEC_W = 5;
    localparam int EXT_VEC_W = 11;
    localparam int NUM_CQ = 8;
    localparam int CQ_W = 3;
    localparam int PTR_W = 8;
    localparam int DATA_W = 32;
    localparam int CAP_W = 3;
    localparam int REQ_VECTORS = 3;

    localparam logic [CAP_W-1:0] VCNT_SINGLE = 3'h0;
    localparam logic [CAP_W-1:0] VCNT_MULTI = 3'h1;
    localparam logic [CAP_W-1:0] VCNT_MAX = 3'h5;
    localparam logic [NUM_VEC-1:0] VEC_ZERO = 32'h0000_0000;
    localparam logic [NUM_VEC-1:0] VEC_ONE = 32'h0000_0001;
    localparam logic [PTR_W-1:0] PTR_RESET = 8'h00;
    localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;
    localparam logic [VEC_W-1:0] VEC_IDX_ZERO = 5'h00;

    typedef enum logic [2:0] {
        MODE_OFF,
        MODE_WIRE,
        MODE_SINGLE,
        MODE_MULTI,
        MODE_EXT
    } mode_e;

    typedef struct packed {
        logic valid;
        logic create;
        logic [CQ_W-1:0] qid;
        logic ien;
        logic [VEC_W-1:0] vector;
    } cq_config_s;

    typedef struct packed {
        logic valid;
        logic [CQ_W-1:0] qid;
        logic [PTR_W-1:0] ptr;
    } cq_event_s;

    typedef struct packed {
        logic valid;
        logic [NUM_VEC-1:0] data;
    } mask_write_s;

    typedef struct packed {
        logic valid;
        logic [VEC_W-1:0] index;
        logic [DATA_W-1:0] data;
    } table_write_s;

    typedef struct packed {
        logic message_interrupt_enable;
        logic [CAP_W-1:0] enabled_vector_count;
        logic ext_enable;
        logic ext_function_mask;
    } irq_cfg_s;

    typedef struct packed {
        logic valid;
        logic [EXT_VEC_W-1:0] vector;
        logic [DATA_W-1:0] data;
    } msg_s;

    // Smallest exponent whose power of two covers the requested vector count.
    function automatic logic [CAP_W-1:0] pow2_exponent(input int count);
        logic [CAP_W-1:0] e;
        e = 3'h0;
        for (int i = 0; i < 6; i++)
        begin
            if ((1 << i) < count)
            begin
                e = CAP_W'(i + 1);
            end
        end
        return e;
    endfunction

endpackage

// ==== vec_pick.sv ====
// Lowest-index picker over a vector of request bits.
`timescale 1ns/10ps
`default_nettype none
module vec_pick (
    // Requests
    input wire logic [cq_irq_pkg::NUM_VEC-1:0] req,
    // Result
    output logic found,
    output logic [cq_irq_pkg::VEC_W-1:0] idx
);
    import cq_irq_pkg::*;

    always_comb
    begin
        found = 1'b0;
        idx = VEC_IDX_ZERO;
        for (int i = NUM_VEC - 1; i >= 0; i--)
        begin
            if (req[i])
            begin
                found = 1'b1;
                idx = VEC_W'(i);
            end
        end
    end
endmodule
`default_nettype wire

// ==== host_model.sv ====
// Host-side sink for interrupt messages that can answer promptly or stall.
`timescale 1ns/10ps
`default_nettype none
module host_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Message link
    input wire cq_irq_pkg::msg_s msg,
    output logic msg_ready,
    // Behaviour and log
    input wire logic slow,
    output logic [7:0] msg_count,
    output cq_irq_pkg::msg_s last_msg
);
    import cq_irq_pkg::*;
    logic [1:0] wait_reg;
    // A slow host keeps ready low for three cycles, so the device must hold a message steady meanwhile.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            msg_ready <= 1'b0;
            msg_count <= 8'h00;
            last_msg <= '0;
            wait_reg <= 2'h0;
        end
        else if (msg.valid && msg_ready)
        begin
            msg_count <= msg_count + 8'h01;
            last_msg <= msg;
            msg_ready <= !slow;
            wait_reg <= 2'h0;
        end
        else if (msg.valid)
        begin
            wait_reg <= wait_reg + 2'h1;
            msg_ready <= !slow || (wait_reg == 2'h2);
        end
        else
        begin
            msg_ready <= !slow;
        end
    end
endmodule
`default_nettype wire

// ==== cq_interrupt_signaling_bench.sv ====
// Self-checking bench for the completion-queue interrupt signalling block.
`timescale 1ns/10ps
`default_nettype none
module cq_interrupt_signaling_bench;
    import cq_irq_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    cq_config_s cq_config = '0;
    cq_event_s cq_tail_update = '0;
    cq_event_s cq_head_doorbell = '0;
    mask_write_s mask_set_register = '0;
    mask_write_s mask_clear_register = '0;
    irq_cfg_s irq_cfg = '0;
    logic [DATA_W-1:0] msi_base_data = 32'h1234_5600;
    logic [NUM_VEC-1:0] ext_vector_mask = '0;
    table_write_s ext_table_write = '0;
    msg_s msg;
    logic msg_ready;
    logic intx_n;
    logic [NUM_VEC-1:0] vector_mask_bits;
    logic [NUM_VEC-1:0] pending_bits;
    logic [CAP_W-1:0] capable_vector_count;
    mode_e mode;
    logic slow = 1'b0;
    logic [7:0] msg_count;
    msg_s last_msg;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;

    cq_interrupt_signaling dut_u (.clk(clk), .rst_n(rst_n), .cq_config(cq_config),
        .cq_tail_update(cq_tail_update), .cq_head_doorbell(cq_head_doorbell),
        .mask_set_register(mask_set_register), .mask_clear_register(mask_clear_register),
        .irq_cfg(irq_cfg), .msi_base_data(msi_base_data), .ext_vector_mask(ext_vector_mask),
        .ext_table_write(ext_table_write), .msg(msg), .msg_ready(msg_ready), .intx_n(intx_n),
        .vector_mask_bits(vector_mask_bits), .pending_bits(pending_bits),
        .capable_vector_count(capable_vector_count), .mode(mode));

    host_model host_u (.clk(clk), .rst_n(rst_n), .msg(msg), .msg_ready(msg_ready), .slow(slow),
        .msg_count(msg_count), .last_msg(last_msg));

    always #50 clk = ~clk;

    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // The whole run needs well under a thousand cycles, so this only cuts a hang.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            give_verdict;
        end
    end

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic create(input int q, input logic ien, input int v);
        @(posedge clk);
        cq_config <= '{1'b1, 1'b1, CQ_W'(q), ien, VEC_W'(v)};
        @(posedge clk);
        cq_config <= '0;
    endtask

    task automatic ev(input bit hd, input int q, input int p);
        cq_event_s e;
        e = '{1'b1, CQ_W'(q), PTR_W'(p)};
        @(posedge clk);
        if (hd)
            cq_head_doorbell <= e;
        else
            cq_tail_update <= e;
        @(posedge clk);
        cq_head_doorbell <= '0;
        cq_tail_update <= '0;
    endtask

    task automatic mask(input bit clr, input logic [NUM_VEC-1:0] d);
        @(posedge clk);
        if (clr)
            mask_clear_register <= '{1'b1, d};
        else
            mask_set_register <= '{1'b1, d};
        @(posedge clk);
        mask_clear_register <= '0;
        mask_set_register <= '0;
    endtask

    task automatic set_mode(input irq_cfg_s c, input mode_e m);
        @(posedge clk);
        irq_cfg <= c;
        settle(1);
        check("mode", mode, m);
    endtask

    // Waits long enough for a stalled host to take one message, then checks the log.
    task automatic wait_msgs(input int n, input int v, input logic [31:0] d);
        settle(12);
        check("msg_count", msg_count, n);
        check("msg_vector", last_msg.vector, v);
        check("msg_data", last_msg.data, d);
    endtask

    initial
    begin
        repeat (5) @(posedge clk);
        check("intx_n", intx_n, 1'b1);
        check("mask_bits", vector_mask_bits, 32'h0000_0000);
        check("msg_valid", msg.valid, 1'b0);
        rst_n <= 1'b1;
        settle(1);
        check("capable", capable_vector_count, 3'h2);
        set_mode('{1'b1, 3'h0, 1'b0, 1'b0}, MODE_SINGLE);
        set_mode('{1'b1, 3'h1, 1'b0, 1'b0}, MODE_MULTI);
        set_mode('{1'b0, 3'h0, 1'b1, 1'b0}, MODE_EXT);
        set_mode('{1'b1, 3'h0, 1'b1, 1'b0}, MODE_OFF);
        set_mode('{1'b0, 3'h0, 1'b0, 1'b0}, MODE_WIRE);
        create(0, 1'b1, 0);
        create(1, 1'b1, 0);
        create(2, 1'b0, 0);
        ev(0, 2, 1);
        settle(0);
        check("intx_n", intx_n, 1'b1);
        ev(0, 0, 1);
        settle(0);
        check("intx_n", intx_n, 1'b0);
        ev(0, 1, 3);
        ev(1, 0, 1);
        settle(0);
        check("intx_n", intx_n, 1'b0);
        ev(1, 1, 2);
        settle(0);
        check("intx_n", intx_n, 1'b0);
        mask(0, 32'h0000_0001);
        settle(0);
        check("intx_n", intx_n, 1'b1);
        mask(1, 32'h0000_0001);
        settle(0);
        check("intx_n", intx_n, 1'b0);
        ev(1, 1, 3);
        settle(0);
        check("intx_n", intx_n, 1'b1);
        set_mode('{1'b1, 3'h2, 1'b0, 1'b0}, MODE_MULTI);
        create(3, 1'b1, 3);
        create(4, 1'b1, 1);
        ev(0, 3, 1);
        wait_msgs(1, 3, 32'h1234_5603);
        // Handler flow: mask, acknowledge, then unmask with nothing left set.
        mask(0, 32'h0000_0008);
        settle(0);
        check("mask_bits", vector_mask_bits, 32'h0000_0008);
        ev(1, 3, 1);
        mask(1, 32'h0000_0008);
        settle(0);
        check("mask_bits", vector_mask_bits, 32'h0000_0000);
        wait_msgs(1, 3, 32'h1234_5603);
        mask(0, 32'h0000_0008);
        ev(0, 3, 2);
        wait_msgs(1, 3, 32'h1234_5603);
        mask(1, 32'h0000_0008);
        wait_msgs(2, 3, 32'h1234_5603);
        @(posedge clk);
        slow <= 1'b1;
        ev(0, 4, 1);
        wait_msgs(3, 1, 32'h1234_5601);
        ev(1, 3, 2);
        wait_msgs(4, 1, 32'h1234_5601);
        ev(1, 4, 1);
        wait_msgs(4, 1, 32'h1234_5601);
        set_mode('{1'b1, 3'h0, 1'b0, 1'b0}, MODE_SINGLE);
        ev(0, 0, 2);
        wait_msgs(5, 0, 32'h1234_5600);
        ev(1, 0, 2);
        @(posedge clk);
        slow <= 1'b0;
        ext_table_write <= '{1'b1, 5'h02, 32'hcafe_0002};
        @(posedge clk);
        ext_table_write <= '0;
        set_mode('{1'b0, 3'h0, 1'b1, 1'b1}, MODE_EXT);
        create(5, 1'b1, 2);
        ev(0, 5, 1);
        settle(1);
        check("pending", pending_bits, 32'h0000_0004);
        check("msg_count", msg_count, 5);
        @(posedge clk);
        irq_cfg.ext_function_mask <= 1'b0;
        wait_msgs(6, 2, 32'hcafe_0002);
        check("pending", pending_bits, 32'h0000_0000);
        @(posedge clk);
        ext_vector_mask <= 32'h0000_0004;
        ev(1, 5, 1);
        ev(0, 5, 2);
        settle(1);
        check("pending", pending_bits, 32'h0000_0004);
        @(posedge clk);
        ext_vector_mask <= 32'h0000_0000;
        wait_msgs(7, 2, 32'hcafe_0002);
        set_mode('{1'b0, 3'h0, 1'b0, 1'b0}, MODE_WIRE);
        mask(0, 32'hff00_0000);
        ev(0, 0, 3);
        settle(0);
        check("intx_n", intx_n, 1'b0);
        @(posedge clk);
        rst_n <= 1'b0;
        settle(0);
        check("intx_n", intx_n, 1'b1);
        check("mask_bits", vector_mask_bits, 32'h0000_0000);
        check("pending", pending_bits, 32'h0000_0000);
        @(posedge clk);
        rst_n <= 1'b1;
        settle(2);
        check("intx_n", intx_n, 1'b1);
        give_verdict;
    end
endmodule
`default_nettype wire
